// *** bench/ufcis_serial_model.sv ***
// stand-in for the serial engine: delivers rx bytes, requests tx bytes
// assumes calls come from the bench just after a rising pclk edge
`default_nettype none
module ufcis_serial_model (
  input wire logic pclk, // system clock
  output logic rx_push, // byte strobe
  output logic [7:0] rx_byte, // received byte
  output logic tx_take // byte request
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_push = 1'b0;
    rx_byte = 8'h00;
    tx_take = 1'b0;
  end
  // each call spans two edges so strobes never re-assert in one step
  task automatic push(input logic [7:0] b);
    rx_push <= 1'b1;
    rx_byte <= b;
    @(posedge pclk);
    rx_push <= 1'b0;
    rx_byte <= ~b; // no stale byte once the strobe drops
    @(posedge pclk);
  endtask
  task automatic take();
    tx_take <= 1'b1;
    @(posedge pclk);
    tx_take <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // ufcis_serial_model
`default_nettype wire

// *** bench/ufcis_top_bench.sv ***
// self-checking bench for ufcis_top over apb plus a serial stand-in
// assumes apb answers with pready in the cycle right after setup
`default_nettype none
module ufcis_top_bench;
  import ufcis_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [6:0] ev = 7'h00;
  logic [31:0] prdata;
  logic pready, pslverr, tx_take, tx_byte_valid, rx_push;
  logic tx_dma_ready_n, rx_dma_ready_n, fifo_enabled;
  logic [7:0] tx_byte, rx_byte, b;
  logic [32:0] rdq[$];
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 22;
  always #10 pclk = ~pclk;
  ufcis_serial_model ser_u (.pclk(pclk), .rx_push(rx_push), .rx_byte(rx_byte),
    .tx_take(tx_take));
  ufcis_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_take(tx_take), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .rx_push(rx_push), .rx_byte(rx_byte),
    .rx_timeout(ev[0]), .line_status_event(ev[1]), .modem_status_event(ev[2]),
    .xoff_match(ev[3]), .xon_match(ev[4]), .special_match(ev[5]),
    .flow_change(ev[6]), .tx_dma_ready_n(tx_dma_ready_n),
    .rx_dma_ready_n(rx_dma_ready_n), .fifo_enabled(fifo_enabled));
  // ----------------------------------------------------------------
  // checking and verdict
  // ----------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // read notes are matched in order; data is ignored on an error reply
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rdq[0][32]) begin
        check({pslverr, 32'h0}, rdq.pop_front());
      end else begin
        check({pslverr, prdata}, rdq.pop_front());
      end
    end
    if (tx_byte_valid === 1'b1) begin
      check({25'h0, tx_byte}, {25'h0, txq.pop_front()});
    end
  end
  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check(33'h1, 33'h0);
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    rdq.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [6:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= 7'h00;
    @(posedge pclk);
  endtask
  // pins are registered from the counts, so let two edges land first
  task automatic pins(input logic t, input logic r);
    repeat (2) @(posedge pclk);
    check({31'h0, tx_dma_ready_n, rx_dma_ready_n}, {31'h0, t, r});
  endtask
  task automatic push_rand();
    b = 8'($random(seed));
    rxq.push_back(b);
    ser_u.push(b);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({32'h0, fifo_enabled}, 33'h0);
    pins(1'b0, 1'b1);
    rd(ADDR_FIFO_CTRL, 32'h01);
    push_rand();
    pins(1'b0, 1'b0);
    rd(ADDR_DATA, {24'h0, rxq.pop_front()});
    pins(1'b0, 1'b1);
    apb(1'b1, ADDR_FIFO_CTRL, 32'hc9);
    check({32'h0, fifo_enabled}, 33'h1);
    rd(ADDR_FIFO_CTRL, 32'hc1);
    repeat (27) push_rand();
    pins(1'b0, 1'b1);
    push_rand();
    pins(1'b0, 1'b0);
    rd(ADDR_FIFO_CTRL, 32'hc4);
    rd(ADDR_DATA, {24'h0, rxq.pop_front()});
    pins(1'b0, 1'b0);
    rd(ADDR_FIFO_CTRL, 32'hc1);
    repeat (27) rd(ADDR_DATA, {24'h0, rxq.pop_front()});
    pins(1'b0, 1'b1);
    pulse(7'h06);
    rd(ADDR_FIFO_CTRL, 32'hc6);
    rd(ADDR_FIFO_CTRL, 32'hc0);
    rd(ADDR_FIFO_CTRL, 32'hc1);
    push_rand();
    pulse(7'h01);
    pins(1'b0, 1'b0);
    rd(ADDR_FIFO_CTRL, 32'hcc);
    rd(ADDR_DATA, {24'h0, rxq.pop_front()});
    pulse(7'h40);
    rd(ADDR_FIFO_CTRL, 32'hc1);
    apb(1'b1, ADDR_ENH, 32'h10);
    pulse(7'h48);
    rd(ADDR_FIFO_CTRL, 32'hd0);
    rd(ADDR_FIFO_CTRL, 32'hd0);
    pulse(7'h10);
    rd(ADDR_FIFO_CTRL, 32'he0);
    rd(ADDR_FIFO_CTRL, 32'hc1);
    pulse(7'h20);
    rd(ADDR_FIFO_CTRL, 32'hd0);
    rd(ADDR_FIFO_CTRL, 32'hc1);
    rd(8'h40, 32'h0, 1'b1);
    repeat (32) begin
      b = 8'($random(seed));
      txq.push_back(b);
      apb(1'b1, ADDR_DATA, {24'h0, b});
    end
    pins(1'b1, 1'b1);
    repeat (15) ser_u.take();
    pins(1'b1, 1'b1);
    ser_u.take();
    pins(1'b0, 1'b1);
    ser_u.take();
    rd(ADDR_FIFO_CTRL, 32'hc2);
    repeat (3) push_rand();
    rd(ADDR_LEVELS, 32'h030f);
    apb(1'b1, ADDR_FIFO_CTRL, 32'hcf);
    rd(ADDR_LEVELS, 32'h0);
    repeat (4) @(posedge pclk);
    end_of_test();
  end
endmodule // ufcis_top_bench
`default_nettype wire

// *** hdl/ufcis_pkg.sv ***
// constants for the uart fifo control and interrupt status block
// assumes one 50 MHz clock and an apb master on the register side
`default_nettype none
package ufcis_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 32;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 6;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;      // write: tx fifo, read: rx fifo
  localparam logic [7:0] ADDR_FIFO_CTRL = 8'h08; // write: fifo_control, read: interrupt_status
  localparam logic [7:0] ADDR_ENH = 8'h0c;       // enhanced_feature_reg
  localparam logic [7:0] ADDR_LEVELS = 8'h10;    // fill counts
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FCR_EN = 0;
  localparam int FCR_RX_CLEAR = 1;
  localparam int FCR_TX_CLEAR = 2;
  localparam int FCR_DMA_MODE = 3;
  localparam int FCR_TX_SEL_LSB = 4;
  localparam int FCR_RX_SEL_LSB = 6;
  localparam int ENH_EN = 4;
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam logic [7:0] ENH_RESET = 8'h00;
  // ----------------------------------------------------------------
  // trigger levels in bytes
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] RX_TRIG_0 = 6'h08;
  localparam logic [CNT_W-1:0] RX_TRIG_1 = 6'h10;
  localparam logic [CNT_W-1:0] RX_TRIG_2 = 6'h18;
  localparam logic [CNT_W-1:0] RX_TRIG_3 = 6'h1c;
  localparam logic [CNT_W-1:0] TX_TRIG_0 = 6'h10;
  localparam logic [CNT_W-1:0] TX_TRIG_1 = 6'h08;
  localparam logic [CNT_W-1:0] TX_TRIG_2 = 6'h18;
  localparam logic [CNT_W-1:0] TX_TRIG_3 = 6'h1e;
  // ----------------------------------------------------------------
  // interrupt identification codes, bits 5..0
  // ----------------------------------------------------------------
  localparam logic [5:0] ISR_NONE = 6'h01;
  localparam logic [5:0] ISR_LINE = 6'h06;
  localparam logic [5:0] ISR_RX_DATA = 6'h04;
  localparam logic [5:0] ISR_RX_TIMEOUT = 6'h0c;
  localparam logic [5:0] ISR_TX_EMPTY = 6'h02;
  localparam logic [5:0] ISR_MODEM = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_LINE = 3'b001,
    SRC_RXD = 3'b010,
    SRC_RXTO = 3'b011,
    SRC_THR = 3'b100,
    SRC_MODEM = 3'b101,
    SRC_XOFF = 3'b110,
    SRC_FLOW = 3'b111
  } ufcis_src_t;
endpackage : ufcis_pkg
`default_nettype wire

// *** hdl/ufcis_top.sv ***
// fifo control, dma ready pins and prioritised interrupt status of a uart
// assumes the serial engine on pclk feeds rx bytes and takes tx bytes
//
// What this block does
// - mode 1: tx ready pin high when full
// - mode 1: tx ready pin low at trigger
// - mode 1: rx ready low at trigger/timeout
// - mode 1: rx ready high only when empty
// - tx clear empties fifo, self-clears
// - rx clear empties fifo, self-clears
// - enable bit turns both fifos on
// - control bits other than enable ignored unless enable set
// - rx trigger codes give 8/16/24/28
// - tx trigger codes give 16/8/24/30
// - status read returns highest pending source
// - read clears only the reported source
// - line status is level 1, 000110
// - rx data 000100, timeout 001100, level 2
// - tx empty is level 3, 000010
// - modem change is level 4, 000000
// - xoff/special match level 5, 010000
// - cts/rts change level 6, 100000
// - bits 7:6 mirror fifo enable
// - bits 5:4 need enhanced enable
// - xoff bit holds until xon
// - bit 0 low while anything pending
// - mode 0: tx ready low while empty
// - mode 0: rx ready low while nonempty
// - rx data source drops below trigger
// - tx empty raised dropping below trigger
`default_nettype none
module ufcis_top
  import ufcis_pkg::*;
#(
  parameter int DEPTH = ufcis_pkg::FIFO_DEPTH
) (
  input wire logic pclk,                        // system clock
  input wire logic presetn,                     // async reset, active low
  input wire logic psel,                        // apb select
  input wire logic penable,                     // apb enable
  input wire logic pwrite,                      // apb direction
  input wire logic [7:0] paddr,                 // apb byte address
  input wire logic [31:0] pwdata,               // apb write data
  output logic [31:0] prdata,                   // apb read data
  output logic pready,                          // apb ready
  output logic pslverr,                         // apb error
  input wire logic tx_take,                     // shifter asks for a byte
  output logic [ufcis_pkg::BYTE_W-1:0] tx_byte, // byte to shifter
  output logic tx_byte_valid,                   // tx_byte valid pulse
  input wire logic rx_push,                     // receiver delivers a byte
  input wire logic [ufcis_pkg::BYTE_W-1:0] rx_byte, // received byte
  input wire logic rx_timeout,                  // receive time-out pulse
  input wire logic line_status_event,           // line error pulse
  input wire logic modem_status_event,          // modem input change pulse
  input wire logic xoff_match,                  // flow-off character seen
  input wire logic xon_match,                   // flow-on character seen
  input wire logic special_match,               // special character seen
  input wire logic flow_change,                 // cts or rts changed
  output logic tx_dma_ready_n,                  // transmit dma ready, low active
  output logic rx_dma_ready_n,                  // receive dma ready, low active
  output logic fifo_enabled                     // fifos in use
);
  import ufcis_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] tx_mem [DEPTH];
  logic [BYTE_W-1:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wr_q, tx_wr_d, tx_rd_q, tx_rd_d;
  logic [AW-1:0] rx_wr_q, rx_wr_d, rx_rd_q, rx_rd_d;
  logic [CNT_W-1:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic [7:0] fcr_q, fcr_d, enh_q, enh_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic pop_ok_q, pop_ok_d;
  ufcis_src_t src_hold_q, src_hold_d, cur_src;
  logic line_q, line_d, rxto_q, rxto_d, thr_q, thr_d, modem_q, modem_d;
  logic xoff_q, xoff_d, spec_q, spec_d, flow_q, flow_d;
  logic [BYTE_W-1:0] tx_byte_q, tx_byte_d;
  logic tx_vld_q, tx_vld_d, txr_n_q, txr_n_d, rxr_n_q, rxr_n_d;
  logic setup, access, tx_push, tx_pop, rx_ok, rx_pop, tx_clr, rx_clr;
  logic mode1, enh, rxd_pend;
  logic [CNT_W-1:0] lim, rx_trig, tx_trig, rx_lvl, tx_lvl;
  logic [5:0] cur_code;

  // ----------------------------------------------------------------
  // trigger selection and priority
  // ----------------------------------------------------------------
  always_comb begin
    case (fcr_q[FCR_RX_SEL_LSB +: 2])
      2'b00: rx_trig = RX_TRIG_0;
      2'b01: rx_trig = RX_TRIG_1;
      2'b10: rx_trig = RX_TRIG_2;
      default: rx_trig = RX_TRIG_3;
    endcase
    case (fcr_q[FCR_TX_SEL_LSB +: 2])
      2'b00: tx_trig = TX_TRIG_0;
      2'b01: tx_trig = TX_TRIG_1;
      2'b10: tx_trig = TX_TRIG_2;
      default: tx_trig = TX_TRIG_3;
    endcase
    // with fifos off each path behaves as a one-byte holding register
    lim = fcr_q[FCR_EN] ? CNT_W'(DEPTH) : CNT_W'(1);
    rx_lvl = fcr_q[FCR_EN] ? rx_trig : CNT_W'(1);
    tx_lvl = fcr_q[FCR_EN] ? tx_trig : CNT_W'(1);
    mode1 = fcr_q[FCR_EN] & fcr_q[FCR_DMA_MODE];
    enh = enh_q[ENH_EN];
    rxd_pend = rx_cnt_q >= rx_lvl;
    cur_src = SRC_NONE;
    cur_code = ISR_NONE;
    if (line_q) begin
      cur_src = SRC_LINE;
      cur_code = ISR_LINE;
    end else if (rxd_pend) begin
      cur_src = SRC_RXD;
      cur_code = ISR_RX_DATA;
    end else if (rxto_q) begin
      cur_src = SRC_RXTO;
      cur_code = ISR_RX_TIMEOUT;
    end else if (thr_q) begin
      cur_src = SRC_THR;
      cur_code = ISR_TX_EMPTY;
    end else if (modem_q) begin
      cur_src = SRC_MODEM;
      cur_code = ISR_MODEM;
    end else if (enh && (xoff_q || spec_q)) begin
      cur_src = SRC_XOFF;
      cur_code = ISR_XOFF;
    end else if (enh && flow_q) begin
      cur_src = SRC_FLOW;
      cur_code = ISR_FLOW;
    end
  end

  // ----------------------------------------------------------------
  // apb slave, fifo control and counters
  // ----------------------------------------------------------------
  // reads are answered from a value frozen in the setup cycle, so the
  // source that a status read clears is exactly the one it returned
  always_comb begin
    setup = psel & ~penable;
    access = psel & penable & pready_q;
    pready_d = setup;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pop_ok_d = pop_ok_q;
    src_hold_d = src_hold_q;
    fcr_d = fcr_q;
    enh_d = enh_q;
    tx_clr = 1'b0;
    rx_clr = 1'b0;
    tx_push = 1'b0;
    rx_pop = 1'b0;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      pop_ok_d = 1'b0;
      src_hold_d = SRC_NONE;
      case (paddr)
        ADDR_DATA: begin
          if (!pwrite) begin
            prdata_d[BYTE_W-1:0] = rx_mem[rx_rd_q];
            pop_ok_d = rx_cnt_q != '0;
          end
        end
        ADDR_FIFO_CTRL: begin
          if (!pwrite) begin
            prdata_d[7:0] = {{2{fcr_q[FCR_EN]}}, cur_code};
            src_hold_d = cur_src;
          end
        end
        ADDR_ENH: prdata_d[7:0] = enh_q;
        ADDR_LEVELS: prdata_d[15:0] = {2'b00, rx_cnt_q, 2'b00, tx_cnt_q};
        default: pslverr_d = 1'b1;
      endcase
    end
    if (access && !pslverr_q) begin
      case (paddr)
        ADDR_DATA: begin
          if (pwrite) begin
            tx_push = tx_cnt_q < lim;
          end else begin
            rx_pop = pop_ok_q;
          end
        end
        ADDR_FIFO_CTRL: begin
          if (pwrite) begin
            if (pwdata[FCR_EN]) begin
              // clear bits are never stored, so fcr_q always holds them at zero
              fcr_d = pwdata[7:0] & 8'hf9;
              tx_clr = pwdata[FCR_TX_CLEAR] | ~fcr_q[FCR_EN];
              rx_clr = pwdata[FCR_RX_CLEAR] | ~fcr_q[FCR_EN];
            end else begin
              fcr_d[FCR_EN] = 1'b0;
              tx_clr = fcr_q[FCR_EN];
              rx_clr = fcr_q[FCR_EN];
            end
          end
        end
        ADDR_ENH: begin
          if (pwrite) begin
            enh_d = pwdata[7:0];
          end
        end
        default: ;
      endcase
    end
    tx_pop = tx_take && tx_cnt_q != '0;
    rx_ok = rx_push && rx_cnt_q < lim; // overflowing bytes are dropped
    tx_byte_d = tx_pop ? tx_mem[tx_rd_q] : tx_byte_q;
    tx_vld_d = tx_pop;
    // a clear wins over a push or pop in the same cycle
    if (tx_clr) begin
      tx_wr_d = '0;
      tx_rd_d = '0;
      tx_cnt_d = '0;
    end else begin
      tx_wr_d = tx_push ? AW'(tx_wr_q + 1'b1) : tx_wr_q;
      tx_rd_d = tx_pop ? AW'(tx_rd_q + 1'b1) : tx_rd_q;
      tx_cnt_d = CNT_W'(tx_cnt_q + CNT_W'(tx_push) - CNT_W'(tx_pop));
    end
    if (rx_clr) begin
      rx_wr_d = '0;
      rx_rd_d = '0;
      rx_cnt_d = '0;
    end else begin
      rx_wr_d = rx_ok ? AW'(rx_wr_q + 1'b1) : rx_wr_q;
      rx_rd_d = rx_pop ? AW'(rx_rd_q + 1'b1) : rx_rd_q;
      rx_cnt_d = CNT_W'(rx_cnt_q + CNT_W'(rx_ok) - CNT_W'(rx_pop));
    end
  end

  // ----------------------------------------------------------------
  // interrupt sources and dma ready pins
  // ----------------------------------------------------------------
  // every sticky source: the hardware set wins over the read clear
  always_comb begin
    line_d = (line_q & ~(access && src_hold_q == SRC_LINE)) | line_status_event;
    rxto_d = (rxto_q & ~(rx_pop | rx_clr | (access && src_hold_q == SRC_RXTO)))
             | rx_timeout;
    thr_d = (thr_q & ~(tx_push | (access && src_hold_q == SRC_THR)))
            | (tx_cnt_q >= tx_lvl && tx_cnt_d < tx_lvl);
    modem_d = (modem_q & ~(access && src_hold_q == SRC_MODEM)) | modem_status_event;
    xoff_d = (xoff_q & ~xon_match) | xoff_match;
    spec_d = (spec_q & ~(access && src_hold_q == SRC_XOFF)) | special_match;
    flow_d = (flow_q & ~(access && src_hold_q == SRC_FLOW)) | flow_change;
    if (mode1) begin
      if (tx_cnt_q == CNT_W'(DEPTH)) begin
        txr_n_d = 1'b1;
      end else if (tx_cnt_q <= tx_trig) begin
        txr_n_d = 1'b0;
      end else begin
        txr_n_d = txr_n_q;
      end
      if (rx_cnt_q >= rx_trig || (rxto_q && rx_cnt_q != '0)) begin
        rxr_n_d = 1'b0;
      end else if (rx_cnt_q == '0) begin
        rxr_n_d = 1'b1;
      end else begin
        rxr_n_d = rxr_n_q;
      end
    end else begin
      txr_n_d = tx_cnt_q != '0;
      rxr_n_d = rx_cnt_q == '0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (tx_push) begin
      tx_mem[tx_wr_q] <= pwdata[BYTE_W-1:0];
    end
    if (rx_ok && !rx_clr) begin
      rx_mem[rx_wr_q] <= rx_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wr_q <= '0;
      tx_rd_q <= '0;
      rx_wr_q <= '0;
      rx_rd_q <= '0;
      tx_cnt_q <= '0;
      rx_cnt_q <= '0;
      fcr_q <= FCR_RESET;
      enh_q <= ENH_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      pop_ok_q <= 1'b0;
      src_hold_q <= SRC_NONE;
      line_q <= 1'b0;
      rxto_q <= 1'b0;
      thr_q <= 1'b0;
      modem_q <= 1'b0;
      xoff_q <= 1'b0;
      spec_q <= 1'b0;
      flow_q <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_vld_q <= 1'b0;
      txr_n_q <= 1'b0;
      rxr_n_q <= 1'b1;
    end else begin
      tx_wr_q <= tx_wr_d;
      tx_rd_q <= tx_rd_d;
      rx_wr_q <= rx_wr_d;
      rx_rd_q <= rx_rd_d;
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      fcr_q <= fcr_d;
      enh_q <= enh_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      pop_ok_q <= pop_ok_d;
      src_hold_q <= src_hold_d;
      line_q <= line_d;
      rxto_q <= rxto_d;
      thr_q <= thr_d;
      modem_q <= modem_d;
      xoff_q <= xoff_d;
      spec_q <= spec_d;
      flow_q <= flow_d;
      tx_byte_q <= tx_byte_d;
      tx_vld_q <= tx_vld_d;
      txr_n_q <= txr_n_d;
      rxr_n_q <= rxr_n_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_byte = tx_byte_q;
  assign tx_byte_valid = tx_vld_q;
  assign tx_dma_ready_n = txr_n_q;
  assign rx_dma_ready_n = rxr_n_q;
  assign fifo_enabled = fcr_q[FCR_EN];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic isr_rd_acc;
  assign isr_rd_acc = access && !pwrite && paddr == ADDR_FIFO_CTRL;

  a_isr_none_bit: assert property (@(posedge pclk) disable iff (!presetn)
    isr_rd_acc |-> prdata_q[0] == (src_hold_q == SRC_NONE))
    else $error("status bit 0 disagrees with pending source");
  a_isr_fifo_bits: assert property (@(posedge pclk) disable iff (!presetn)
    isr_rd_acc |-> prdata_q[7:6] == {2{fcr_q[FCR_EN]}})
    else $error("status bits 7:6 do not mirror fifo enable");
  a_isr_enh_gate: assert property (@(posedge pclk) disable iff (!presetn)
    isr_rd_acc && !enh_q[ENH_EN] |-> prdata_q[5:4] == 2'b00)
    else $error("status bits 5:4 set without enhanced enable");
  a_line_top_prio: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == ADDR_FIFO_CTRL && line_q |=> prdata_q[5:0] == 6'h06)
    else $error("line status not reported first");
  a_read_clear_one: assert property (@(posedge pclk) disable iff (!presetn)
    isr_rd_acc && src_hold_q == SRC_LINE && !line_status_event && modem_q
    |=> !line_q && modem_q)
    else $error("status read cleared the wrong source");
  a_tx_clear: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == ADDR_FIFO_CTRL && pwdata[0] && pwdata[2]
    |=> tx_cnt_q == '0 && fcr_q[FCR_TX_CLEAR] == 1'b0)
    else $error("tx fifo clear did not empty it");
  a_rx_clear: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == ADDR_FIFO_CTRL && pwdata[0] && pwdata[1]
    |=> rx_cnt_q == '0 && fcr_q[FCR_RX_CLEAR] == 1'b0)
    else $error("rx fifo clear did not empty it");
  a_fcr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == ADDR_FIFO_CTRL && !pwdata[0]
    |=> !fcr_q[FCR_EN] && fcr_q[7:1] == $past(fcr_q[7:1]))
    else $error("control bits changed without enable");
  a_rx_dma_hold: assert property (@(posedge pclk) disable iff (!presetn)
    mode1 && !rxr_n_q && rx_cnt_q != '0 && !access |=> !rxr_n_q)
    else $error("rx dma ready released before empty");
  a_tx_dma_full: assert property (@(posedge pclk) disable iff (!presetn)
    mode1 && tx_cnt_q == CNT_W'(DEPTH) && !access |=> tx_dma_ready_n)
    else $error("tx dma ready not high when full");
  a_rx_trig_28: assert property (@(posedge pclk) disable iff (!presetn)
    mode1 && fcr_q[7:6] == 2'b11 && rx_cnt_q == 6'h1c && !access |=> !rx_dma_ready_n)
    else $error("rx trigger 28 not honoured");
  a_xoff_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    xoff_q && !xon_match |=> xoff_q)
    else $error("xoff flag dropped without xon");

  c_isr_read_line: cover property (@(posedge pclk) disable iff (!presetn)
    isr_rd_acc && src_hold_q == SRC_LINE);
  c_rx_dma_mode1: cover property (@(posedge pclk) disable iff (!presetn)
    mode1 && $fell(rx_dma_ready_n));
  c_tx_full: cover property (@(posedge pclk) disable iff (!presetn)
    tx_cnt_q == CNT_W'(DEPTH));
endmodule // ufcis_top
`default_nettype wire
